// ---- bench/rtcc_control_sva.sv ----
// assertion checker for the rtc control register block
`timescale 1ns/1ps
`default_nettype none
module rtcc_control_sva
    import rtcc_pkg::*;
#(
    parameter int TIMER_W = RTCC_TIMER_W,
    parameter logic [RTCC_LOST_W-1:0] LOST_LIMIT = RTCC_LOST_CYCLES[RTCC_LOST_W-1:0]
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [RTCC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [RTCC_DATA_W-1:0] avs_writedata,
    input wire logic [RTCC_BE_W-1:0] avs_byteenable,
    input wire logic [RTCC_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic slow_osc_in,
    input wire logic slow_osc_enable,
    input wire logic slow_osc_bias_enable,
    input wire logic osc_failure_flag,
    input wire logic alarm_event
);
    logic wr_ctrl;
    logic rd_done;
    logic unmapped;
    logic det_en_r;
    logic aen_r;
    // bus transfers completing at this edge
    assign wr_ctrl = avs_write && !avs_waitrequest && avs_address == RTCC_OFS_CTRL && avs_byteenable[0];
    assign rd_done = avs_read && !avs_waitrequest;
    assign unmapped = avs_address != RTCC_OFS_CTRL && avs_address != RTCC_OFS_SNAP && avs_address != RTCC_OFS_MATCH;
    // shadows of the detector enable and alarm enable bits
    always_ff @(posedge clk) begin
        if (!nrst) begin
            det_en_r <= 1'b0;
            aen_r <= 1'b0;
        end else if (wr_ctrl) begin
            det_en_r <= avs_writedata[RTCC_BIT_LOST_EN];
            aen_r <= avs_writedata[RTCC_BIT_AEN];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_aen_off;
        wr_ctrl && !avs_writedata[RTCC_BIT_AEN];
    endsequence
    chk_wait_answer: assert property (s_req_wait |=> !avs_waitrequest)
        else $error("waitrequest late");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_osc_bias_pair: assert property (slow_osc_enable == slow_osc_bias_enable)
        else $error("bias differs from oscillator enable");
    chk_osc_on_write: assert property (wr_ctrl && avs_writedata[7] |-> ##[1:2] slow_osc_enable)
        else $error("oscillator not enabled");
    chk_fail_sticky: assert property (
        osc_failure_flag && !(wr_ctrl && !avs_writedata[5]) |=> osc_failure_flag)
        else $error("failure flag dropped");
    chk_fail_needs_det: assert property (
        $rose(osc_failure_flag) |-> det_en_r || $past(det_en_r) || $past(det_en_r, 2))
        else $error("failure flag without detector");
    chk_aen_clears: assert property (s_aen_off |-> ##2 !alarm_event)
        else $error("alarm not cleared");
    chk_alarm_needs_en: assert property ($rose(alarm_event) |-> $past(aen_r, 2))
        else $error("alarm without enable");
    chk_unmapped_zero: assert property (rd_done && unmapped |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_ctrl_read: assert property (rd_done && avs_address == RTCC_OFS_CTRL |->
        avs_readdata[31:8] == 24'h0 && avs_readdata[7] == slow_osc_enable)
        else $error("control read wrong");
endmodule
bind rtcc_control rtcc_control_sva #(.TIMER_W(TIMER_W), .LOST_LIMIT(LOST_LIMIT)) rtcc_control_sva_i (
    .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .slow_osc_in(slow_osc_in), .slow_osc_enable(slow_osc_enable),
    .slow_osc_bias_enable(slow_osc_bias_enable), .osc_failure_flag(osc_failure_flag),
    .alarm_event(alarm_event));
`default_nettype wire

// ---- bench/rtcc_control_tb.sv ----
// self-checking testbench for the rtc control register block
`timescale 1ns/1ps
`default_nettype none
module rtcc_control_tb import rtcc_pkg::*; ;
    logic clk = 1'h0, nrst = 1'h0, avs_read = 1'h0, avs_write = 1'h0, slow_osc_in = 1'h0, slow_run = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, v, w;
    logic [3:0] be = 4'hF;
    logic [1:0] sc = 2'h0;
    logic avs_waitrequest, slow_osc_enable, slow_osc_bias_enable, osc_failure_flag, alarm_event;
    int err_count = 0, tests_run = 0, n;
    rtcc_control #(.LOST_LIMIT(12'h014)) rtcc_control_i (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slow_osc_in(slow_osc_in),
        .slow_osc_enable(slow_osc_enable), .slow_osc_bias_enable(slow_osc_bias_enable),
        .osc_failure_flag(osc_failure_flag), .alarm_event(alarm_event));
    // 25 MHz system clock
    always #20 clk = ~clk;
    // slow oscillator: period of 8 clocks while running, stands still otherwise
    always @(posedge clk) begin
        if (slow_run) begin
            sc <= sc + 2'h1;
            if (sc == 2'h3) begin
                slow_osc_in <= !slow_osc_in;
            end
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic timeout();
        err_count++;
        $display("[ERR] %0t: wait ran out", $time);
        final_report();
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0) begin
            timeout();
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask
    task automatic ctl(input logic [7:0] c);
        wr(RTCC_OFS_CTRL, {24'h0, c});
    endtask
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask
    // read control until a request bit has cleared
    task automatic poll(input int b);
        logic [31:0] q;
        int k;
        k = 0;
        do begin
            rd(RTCC_OFS_CTRL, q);
            k++;
        end while (q[b] !== 1'b0 && k < 40);
        if (q[b] !== 1'b0) begin
            timeout();
        end
    endtask
    task automatic snap(input logic [7:0] c, output logic [31:0] q);
        ctl(c | 8'h01);
        poll(0);
        rd(RTCC_OFS_SNAP, q);
    endtask
    // wait for the alarm output level; a wait that must succeed counts a run-out
    task automatic wait_alarm(input logic lv, input int lim, input logic must);
        n = 0;
        while (alarm_event !== lv && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (must && alarm_event !== lv) begin
            timeout();
        end
    endtask
    task automatic t_reset();
        check(32'({slow_osc_enable, slow_osc_bias_enable, osc_failure_flag, alarm_event}), 32'h0);
        rd(RTCC_OFS_CTRL, v);
        check(v & 32'hFFFF_FFDF, 32'h0);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, v);
        check(v, 32'h0);
    endtask
    task automatic t_osc();
        ctl(8'h80);
        settle();
        check(32'({slow_osc_enable, slow_osc_bias_enable}), 32'h3);
        @(posedge clk);
        be <= 4'hE;
        ctl(8'h00);
        be <= 4'hF;
        settle();
        check(32'(slow_osc_enable), 32'h1);
    endtask
    task automatic t_load();
        wr(RTCC_OFS_SNAP, 32'h0000_0100);
        ctl(8'h82);
        repeat (30) @(posedge clk);
        rd(RTCC_OFS_CTRL, v);
        check(32'(v[1]), 32'h1);
        slow_run <= 1'b1;
        poll(1);
        snap(8'h80, v);
        check(v, 32'h0000_0100);
        ctl(8'h90);
        repeat (80) @(posedge clk);
        snap(8'h80, v);
        check(32'(v > 32'h100 && v < 32'h10F), 32'h1);
        repeat (40) @(posedge clk);
        snap(8'h80, w);
        check(w, v);
    endtask
    task automatic t_alarm();
        wr(RTCC_OFS_MATCH, 32'h3);
        wr(RTCC_OFS_SNAP, 32'h0);
        ctl(8'h92);
        wait_alarm(1'b1, 80, 1'b0);
        check(32'(n), 32'h50);
        ctl(8'h9A);
        wait_alarm(1'b1, 80, 1'b1);
        check(32'(n < 80), 32'h1);
        wait_alarm(1'b0, 20, 1'b1);
        check(32'(n < 10), 32'h1);
        ctl(8'h9A);
        wait_alarm(1'b1, 80, 1'b1);
        rd(RTCC_OFS_CTRL, v);
        check(32'(v[2]), 32'h1);
        ctl(8'h9A);
        wait_alarm(1'b1, 80, 1'b1);
        ctl(8'h90);
        settle();
        check(32'(alarm_event), 32'h0);
    endtask
    // auto reset on, then off: the count after an alarm must differ
    task automatic t_auto();
        ctl(8'h9E);
        wait_alarm(1'b1, 80, 1'b1);
        wait_alarm(1'b0, 20, 1'b1);
        repeat (8) @(posedge clk);
        snap(8'h9C, v);
        check(32'(v < 32'h3), 32'h1);
        ctl(8'h9A);
        wait_alarm(1'b1, 80, 1'b1);
        wait_alarm(1'b0, 20, 1'b1);
        repeat (8) @(posedge clk);
        snap(8'h98, v);
        check(32'(v > 32'h3), 32'h1);
    endtask
    task automatic t_lost();
        slow_run <= 1'b0;
        ctl(8'h80);
        repeat (40) @(posedge clk);
        check(32'(osc_failure_flag), 32'h0);
        ctl(8'hC0);
        repeat (10) @(posedge clk);
        check(32'(osc_failure_flag), 32'h0);
        repeat (30) @(posedge clk);
        check(32'(osc_failure_flag), 32'h1);
        slow_run <= 1'b1;
        repeat (40) @(posedge clk);
        check(32'(osc_failure_flag), 32'h1);
        ctl(8'hC0);
        settle();
        check(32'(osc_failure_flag), 32'h0);
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_osc();
        t_load();
        t_alarm();
        t_auto();
        t_lost();
        final_report();
    end
endmodule
`default_nettype wire

// ---- shared/rtcc_pkg.sv ----
// constants shared by the rtc control, timer and lost clock detector
package rtcc_pkg;

    // system clock and lost clock timeout
    localparam int unsigned RTCC_CLK_HZ = 25000000;
    localparam int unsigned RTCC_HZ_PER_MHZ = 1000000;
    localparam int unsigned RTCC_LOST_TIME_US = 100;
    localparam int unsigned RTCC_LOST_CYCLES = RTCC_LOST_TIME_US * (RTCC_CLK_HZ / RTCC_HZ_PER_MHZ);
    localparam int RTCC_LOST_W = 12;

    // timer width
    localparam int RTCC_TIMER_W = 32;

    // avalon slave shape
    localparam int RTCC_ADDR_W = 8;
    localparam int RTCC_DATA_W = 32;
    localparam int RTCC_BE_W = 4;

    // register byte addresses
    localparam logic [7:0] RTCC_OFS_CTRL = 8'h04;
    localparam logic [7:0] RTCC_OFS_SNAP = 8'h08;
    localparam logic [7:0] RTCC_OFS_MATCH = 8'h0C;

    // control and status bit positions
    localparam int RTCC_BIT_OSC_EN = 7;
    localparam int RTCC_BIT_LOST_EN = 6;
    localparam int RTCC_BIT_FAIL = 5;
    localparam int RTCC_BIT_RUN = 4;
    localparam int RTCC_BIT_AEN = 3;
    localparam int RTCC_BIT_ALARM = 2;
    localparam int RTCC_BIT_LOAD = 1;
    localparam int RTCC_BIT_SNAP = 0;

    // reset values
    localparam logic RTCC_RST_BIT = 1'b0;
    localparam logic RTCC_RST_FAIL = 1'b0;
    localparam logic [31:0] RTCC_RST_WORD = 32'h0000_0000;

endpackage

// ---- src/rtcc_control.sv ----
// rtc control and status register block with avalon slave
`timescale 1ns/1ps
`default_nettype none

// Contract
// - oscillator enable bit switches slow oscillator and bias currents on or off.
// - lost clock detector runs only while its enable bit is one.
// - hardware sets the oscillator failure flag on a detector timeout.
// - failure flag stays set until software clears it.
// - failure flag is undefined while the oscillator is off.
// - run bit zero holds the timer count; one lets it count.
// - alarm events occur only while alarm enable is one.
// - writing alarm enable zero also clears the alarm flag.
// - set bit loads timer from capture value, hardware clears it when done.
// - capture bit copies timer to capture value, hardware clears it when done.
// - alarm flag lasts at most one slow oscillator cycle; the code holds it while run is zero and the count equals match.
// - detector times out when oscillator level stands over 100 us.
// - alarm bit reads alarm flag; writes set the auto reset enable.
// - auto reset clears timer one slow cycle after alarm deasserts.
// - alarm fires when timer exactly equals the match value.
module rtcc_control
    import rtcc_pkg::*;
#(
    parameter int TIMER_W = RTCC_TIMER_W,
    parameter logic [RTCC_LOST_W-1:0] LOST_LIMIT = RTCC_LOST_CYCLES[RTCC_LOST_W-1:0]
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [RTCC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [RTCC_DATA_W-1:0] avs_writedata,
    input wire logic [RTCC_BE_W-1:0] avs_byteenable,
    output logic [RTCC_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic slow_osc_in,
    output logic slow_osc_enable,
    output logic slow_osc_bias_enable,
    output logic osc_failure_flag,
    output logic alarm_event
);

    // address match used by both read and write decode
    function automatic logic addr_hit(input logic [RTCC_ADDR_W-1:0] addr, input logic [7:0] ofs);
        addr_hit = (addr == ofs);
    endfunction

    // byte lane merge for word registers
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        be_merge = res;
    endfunction

    // control and status state
    logic osc_en_r;
    logic lost_en_r;
    logic fail_r;
    logic run_r;
    logic aen_r;
    logic autorst_r;
    logic load_req_r;
    logic snap_req_r;
    logic [TIMER_W-1:0] capture_r;
    logic [TIMER_W-1:0] match_r;

    // bus handshake state
    logic wait_r;
    logic wait_nxt;
    logic [RTCC_DATA_W-1:0] rdata_r;
    logic [RTCC_DATA_W-1:0] rdata_nxt;

    // slow oscillator synchroniser and edge detect
    logic osc_s1_r;
    logic osc_s2_r;
    logic osc_s3_r;
    logic tick;

    // sub block links
    logic lost_timeout;
    logic alarm_flag;
    logic load_done;
    logic snap_done;
    logic [TIMER_W-1:0] snap_value;

    // decoded bus events
    logic req;
    logic done;
    logic wr_ctrl;
    logic wr_snap;
    logic wr_match;
    logic [7:0] ctrl_byte;

    // request is accepted at the edge where waitrequest is low
    assign req = avs_read || avs_write;
    assign done = req && !wait_r;
    assign wr_ctrl = done && avs_write && addr_hit(avs_address, RTCC_OFS_CTRL) && avs_byteenable[0];
    assign wr_snap = done && avs_write && addr_hit(avs_address, RTCC_OFS_SNAP);
    assign wr_match = done && avs_write && addr_hit(avs_address, RTCC_OFS_MATCH);

    // outputs taken straight from state flops
    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign slow_osc_enable = osc_en_r;
    assign slow_osc_bias_enable = osc_en_r;
    assign osc_failure_flag = fail_r;

    // status byte as software sees it
    always_comb begin
        ctrl_byte = 8'h00;
        ctrl_byte[RTCC_BIT_OSC_EN] = osc_en_r;
        ctrl_byte[RTCC_BIT_LOST_EN] = lost_en_r;
        ctrl_byte[RTCC_BIT_FAIL] = fail_r;
        ctrl_byte[RTCC_BIT_RUN] = run_r;
        ctrl_byte[RTCC_BIT_AEN] = aen_r;
        ctrl_byte[RTCC_BIT_ALARM] = alarm_flag;
        ctrl_byte[RTCC_BIT_LOAD] = load_req_r;
        ctrl_byte[RTCC_BIT_SNAP] = snap_req_r;
    end

    // one wait cycle, then a single cycle with waitrequest low
    always_comb begin
        wait_nxt = !(req && wait_r);
    end

    // read mux sampled when waitrequest drops; unmapped reads give zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (req && wait_r && avs_read) begin
            if (addr_hit(avs_address, RTCC_OFS_CTRL)) begin
                rdata_nxt = {24'h000000, ctrl_byte};
            end else if (addr_hit(avs_address, RTCC_OFS_SNAP)) begin
                rdata_nxt = capture_r;
            end else if (addr_hit(avs_address, RTCC_OFS_MATCH)) begin
                rdata_nxt = match_r;
            end else begin
                rdata_nxt = RTCC_RST_WORD;
            end
        end
    end

    // bus handshake flops
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wait_r <= 1'b1;
            rdata_r <= RTCC_RST_WORD;
        end else begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // oscillator pin passes two flops before any use
    always_ff @(posedge clk) begin
        if (!nrst) begin
            osc_s1_r <= RTCC_RST_BIT;
            osc_s2_r <= RTCC_RST_BIT;
            osc_s3_r <= RTCC_RST_BIT;
        end else begin
            osc_s1_r <= slow_osc_in;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    // one slow oscillator cycle is one rising edge, only while enabled
    assign tick = osc_s2_r && !osc_s3_r && osc_en_r;

    // plain read and write control bits
    always_ff @(posedge clk) begin
        if (!nrst) begin
            osc_en_r <= RTCC_RST_BIT;
            lost_en_r <= RTCC_RST_BIT;
            run_r <= RTCC_RST_BIT;
            aen_r <= RTCC_RST_BIT;
            autorst_r <= RTCC_RST_BIT;
        end else if (wr_ctrl) begin
            osc_en_r <= avs_writedata[RTCC_BIT_OSC_EN];
            lost_en_r <= avs_writedata[RTCC_BIT_LOST_EN];
            run_r <= avs_writedata[RTCC_BIT_RUN];
            aen_r <= avs_writedata[RTCC_BIT_AEN];
            autorst_r <= avs_writedata[RTCC_BIT_ALARM];
        end
    end

    // failure flag: hardware set wins over a software clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fail_r <= RTCC_RST_FAIL;
        end else if (lost_timeout) begin
            fail_r <= 1'b1;
        end else if (wr_ctrl && !avs_writedata[RTCC_BIT_FAIL]) begin
            fail_r <= 1'b0;
        end
    end

    // load request: software sets, completion from the timer clears
    always_ff @(posedge clk) begin
        if (!nrst) begin
            load_req_r <= RTCC_RST_BIT;
        end else if (wr_ctrl && avs_writedata[RTCC_BIT_LOAD]) begin
            load_req_r <= 1'b1;
        end else if (load_done) begin
            load_req_r <= 1'b0;
        end
    end

    // snapshot request: software sets, completion from the timer clears
    always_ff @(posedge clk) begin
        if (!nrst) begin
            snap_req_r <= RTCC_RST_BIT;
        end else if (wr_ctrl && avs_writedata[RTCC_BIT_SNAP]) begin
            snap_req_r <= 1'b1;
        end else if (snap_done) begin
            snap_req_r <= 1'b0;
        end
    end

    // capture word: software load value or timer snapshot
    always_ff @(posedge clk) begin
        if (!nrst) begin
            capture_r <= TIMER_W'(RTCC_RST_WORD);
        end else if (snap_done) begin
            capture_r <= snap_value;
        end else if (wr_snap) begin
            capture_r <= be_merge(capture_r, avs_writedata, avs_byteenable);
        end
    end

    // alarm match word
    always_ff @(posedge clk) begin
        if (!nrst) begin
            match_r <= TIMER_W'(RTCC_RST_WORD);
        end else if (wr_match) begin
            match_r <= be_merge(match_r, avs_writedata, avs_byteenable);
        end
    end

    // alarm event output follows the flag
    always_ff @(posedge clk) begin
        if (!nrst) begin
            alarm_event <= RTCC_RST_BIT;
        end else begin
            alarm_event <= alarm_flag;
        end
    end

    // lost clock detector watches the synchronised level
    rtcc_lost_clk #(
        .CNT_W(RTCC_LOST_W),
        .LIMIT(LOST_LIMIT)
    ) u_lost (
        .clk(clk),
        .nrst(nrst),
        .enable(lost_en_r),
        .level(osc_s2_r),
        .timeout(lost_timeout)
    );

    // timer, alarm and transfers on the slow tick
    rtcc_timer #(
        .WIDTH(TIMER_W)
    ) u_timer (
        .clk(clk),
        .nrst(nrst),
        .tick(tick),
        .run(run_r),
        .load_req(load_req_r),
        .load_value(capture_r),
        .snap_req(snap_req_r),
        .alarm_en(aen_r),
        .alarm_clr(wr_ctrl && !avs_writedata[RTCC_BIT_AEN]),
        .auto_reset(autorst_r),
        .match_value(match_r),
        .snap_value(snap_value),
        .load_done(load_done),
        .snap_done(snap_done),
        .alarm_flag(alarm_flag)
    );

endmodule

`default_nettype wire

// ---- src/rtcc_lost_clk.sv ----
// missing slow clock detector: flags a stuck oscillator level
`timescale 1ns/1ps
`default_nettype none

module rtcc_lost_clk
    import rtcc_pkg::*;
#(
    parameter int CNT_W = RTCC_LOST_W,
    parameter logic [RTCC_LOST_W-1:0] LIMIT = RTCC_LOST_CYCLES[RTCC_LOST_W-1:0]
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic level,
    output logic timeout
);

    logic level_d_r;
    logic [CNT_W-1:0] cnt_r;
    logic stuck;

    assign stuck = (level == level_d_r);

    // remember the last level to find edges
    always_ff @(posedge clk) begin
        if (!nrst) begin
            level_d_r <= RTCC_RST_BIT;
        end else begin
            level_d_r <= level;
        end
    end

    // cycles since the last edge, saturating at the limit
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_r <= '0;
        end else if (!enable || !stuck) begin
            cnt_r <= '0;
        end else if (cnt_r != LIMIT) begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    // one shot pulse when the level has stood past the limit
    always_ff @(posedge clk) begin
        if (!nrst) begin
            timeout <= RTCC_RST_BIT;
        end else begin
            timeout <= enable && stuck && (cnt_r == LIMIT - CNT_W'(1));
        end
    end

endmodule

`default_nettype wire

// ---- src/rtcc_timer.sv ----
// 32-bit slow tick timer with load, snapshot, alarm match and auto reset
`timescale 1ns/1ps
`default_nettype none

module rtcc_timer
    import rtcc_pkg::*;
#(
    parameter int WIDTH = RTCC_TIMER_W
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic run,
    input wire logic load_req,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic snap_req,
    input wire logic alarm_en,
    input wire logic alarm_clr,
    input wire logic auto_reset,
    input wire logic [WIDTH-1:0] match_value,
    output logic [WIDTH-1:0] snap_value,
    output logic load_done,
    output logic snap_done,
    output logic alarm_flag
);

    logic [WIDTH-1:0] count_r;
    logic alarm_prev_r;

    // counter: load first, then auto reset, then run
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_r <= WIDTH'(RTCC_RST_WORD);
        end else if (tick) begin
            if (load_req) begin
                count_r <= load_value;
            end else if (auto_reset && alarm_prev_r && !alarm_flag) begin
                count_r <= '0;
            end else if (run) begin
                count_r <= count_r + WIDTH'(1);
            end
        end
    end

    // snapshot copy and completion pulses
    always_ff @(posedge clk) begin
        if (!nrst) begin
            snap_value <= WIDTH'(RTCC_RST_WORD);
            snap_done <= RTCC_RST_BIT;
            load_done <= RTCC_RST_BIT;
        end else begin
            if (tick && snap_req) begin
                snap_value <= count_r;
            end
            snap_done <= tick && snap_req;
            load_done <= tick && load_req;
        end
    end

    // alarm flag is recomputed on each slow tick; it lives one tick while the count moves on
    always_ff @(posedge clk) begin
        if (!nrst) begin
            alarm_flag <= RTCC_RST_BIT;
            alarm_prev_r <= RTCC_RST_BIT;
        end else if (alarm_clr) begin
            alarm_flag <= RTCC_RST_BIT;
            alarm_prev_r <= RTCC_RST_BIT;
        end else if (tick) begin
            alarm_flag <= alarm_en && (count_r == match_value);
            alarm_prev_r <= alarm_flag;
        end
    end

endmodule

`default_nettype wire
